// ---- hdl/tcdl_loader.sv ----
// Serial load logic of a twelve-channel eight-bit converter
`timescale 1ns/1ps
`default_nettype none
module tcdl_loader
    import tcdl_pkg::*;
#(
    parameter int NCH = NUM_CHAN
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire tcdl_pkg::tcdl_link_t  link,
    input  wire logic                  midscale_preset_n,
    input  wire logic                  power_down_n,
    output logic [NCH-1:0][CODE_W-1:0] channel_code_reg,
    output logic [NCH-1:0]             output_float,
    output logic                       converter_enable,
    output logic                       load_done
);
    import tcdl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_raw;
    logic [3:0] pins_sync;
    logic       cs_n_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       pdn_s;

    assign pins_raw = {link.chip_select_n, link.serial_clk, link.serial_data_in,
                       power_down_n};

    tcdl_sync #(.WIDTH(4)) u_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .async_in  (pins_raw),
        .sync_out  (pins_sync)
    );

    assign {cs_n_s, sclk_s, sdi_s, pdn_s} = pins_sync;

    // ------------------------------------------------------------
    // Edge detection and frame control
    // ------------------------------------------------------------
    logic        sclk_d;
    logic        cs_n_d;
    logic        sclk_rise;
    logic        cs_rise;
    tcdl_state_t state;
    tcdl_state_t next_state;
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] next_shift_reg;
    tcdl_word_t  word;

    // Sampling follows a serial clock up to about a quarter of clk_sys
    assign sclk_rise = sclk_s & ~sclk_d;
    assign cs_rise   = cs_n_s & ~cs_n_d;

    always_comb begin
        next_state     = state;
        next_shift_reg = shift_reg;
        unique case (state)
            TCDL_IDLE: begin
                if (!cs_n_s) begin
                    next_state = TCDL_SHIFT;
                end
            end
            TCDL_SHIFT: begin
                // Select rise wins over a clock rise; the host holds the clock high then
                if (cs_rise) begin
                    next_state = TCDL_LOAD;
                end else if (sclk_rise) begin
                    // Older bits fall off the top, keeping the last twelve
                    next_shift_reg = {shift_reg[WORD_W-2:0], sdi_s};
                end
            end
            TCDL_LOAD: begin
                next_state = cs_n_s ? TCDL_IDLE : TCDL_SHIFT;
            end
            default: begin
                next_state = TCDL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state     <= TCDL_IDLE;
            shift_reg <= SHIFT_RESET;
            sclk_d    <= 1'b1;
            cs_n_d    <= 1'b1;
        end else begin
            state     <= next_state;
            shift_reg <= next_shift_reg;
            sclk_d    <= sclk_s;
            cs_n_d    <= cs_n_s;
        end
    end

    // ------------------------------------------------------------
    // Midscale preset
    // ------------------------------------------------------------
    // The preset pin sets the channel registers to midscale at once; its release
    // passes two flip-flops so no register leaves preset near a clock edge
    logic preset_arst_n;
    logic preset_hold;
    logic preset_rstn;
    logic next_preset_hold;
    logic next_preset_rstn;

    assign preset_arst_n = rstn & midscale_preset_n;

    always_comb begin
        next_preset_hold = 1'b1;
        next_preset_rstn = preset_hold;
    end

    always_ff @(posedge clk_sys or negedge preset_arst_n) begin
        if (!preset_arst_n) begin
            preset_hold <= 1'b0;
            preset_rstn <= 1'b0;
        end else begin
            preset_hold <= next_preset_hold;
            preset_rstn <= next_preset_rstn;
        end
    end

    // ------------------------------------------------------------
    // Address decode and channel registers
    // ------------------------------------------------------------
    assign word = tcdl_word_t'(shift_reg);

    logic [NCH-1:0] chan_hit;
    logic           next_load_done;

    // One strobe per channel in the load cycle; high addresses strobe none
    always_comb begin
        chan_hit       = '0;
        next_load_done = 1'b0;
        // Short frames load from whatever the register holds
        if (state == TCDL_LOAD) begin
            next_load_done = 1'b1;
            for (int i = 0; i < NCH; i++) begin
                // Binary index, zero is the first channel
                chan_hit[i] = (word.channel_addr_field == ADDR_W'(i));
            end
        end
    end

    // Registers hold their codes through shutdown
    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
            logic [CODE_W-1:0] chan_code;
            logic [CODE_W-1:0] next_chan_code;

            always_comb begin
                next_chan_code = chan_code;
                if (chan_hit[ch]) begin
                    next_chan_code = word.channel_code_field;
                end
            end

            always_ff @(posedge clk_sys or negedge preset_rstn) begin
                if (!preset_rstn) begin
                    chan_code <= MIDSCALE_CODE;
                end else begin
                    chan_code <= next_chan_code;
                end
            end

            assign channel_code_reg[ch] = chan_code;
        end
    endgenerate

    // Load strobe rises together with the new code
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            load_done <= 1'b0;
        end else begin
            load_done <= next_load_done;
        end
    end

    // ------------------------------------------------------------
    // Shutdown control
    // ------------------------------------------------------------
    logic [NCH-1:0] next_float;
    logic           next_enable;

    // Shutdown floats the outputs and clears converter_enable; channel registers and loads carry on
    always_comb begin
        next_float  = {NCH{~pdn_s}};
        next_enable = pdn_s;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            output_float     <= '0;
            converter_enable <= 1'b1;
        end else begin
            output_float     <= next_float;
            converter_enable <= next_enable;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/tcdl_pkg.sv ----
// Package of shared constants and types for the twelve-channel converter loader
package tcdl_pkg;

    localparam int NUM_CHAN      = 12;
    localparam int ADDR_W        = 4;
    localparam int CODE_W        = 8;
    localparam int WORD_W        = ADDR_W + CODE_W;
    localparam int ADDR_MSB      = WORD_W - 1;
    localparam int CODE_MSB      = CODE_W - 1;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [7:0] CODE_RESET    = MIDSCALE_CODE;
    localparam logic [11:0] SHIFT_RESET  = 12'h000;
    localparam int SYNC_STAGES   = 2;
    // Highest documented link rate; the sampled link keeps up to about clk_sys/4
    localparam int LINK_MAX_MHZ  = 33;
    localparam int SYS_CLK_MHZ   = 50;

    typedef logic [CODE_W-1:0] tcdl_code_t;

    typedef struct packed {
        logic chip_select_n;
        logic serial_clk;
        logic serial_data_in;
    } tcdl_link_t;

    typedef struct packed {
        logic [ADDR_W-1:0] channel_addr_field;
        logic [CODE_W-1:0] channel_code_field;
    } tcdl_word_t;

    typedef enum logic [1:0] {
        TCDL_IDLE  = 2'b00,
        TCDL_SHIFT = 2'b01,
        TCDL_LOAD  = 2'b11
    } tcdl_state_t;

endpackage

// ---- hdl/tcdl_sync.sv ----
// Two-stage synchroniser for the link pins and the power-down pin
`timescale 1ns/1ps
`default_nettype none
module tcdl_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    // Reset level is all ones: every pin here but serial data idles high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stage1   <= '1;
            sync_out <= '1;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tcdl_host.sv ----
// Host model driving the three-wire load link
`timescale 1ns/1ps
`default_nettype none
module tcdl_host
    import tcdl_pkg::*;
(
    input wire logic             clk_sys,
    output var tcdl_pkg::tcdl_link_t link
);
    import tcdl_pkg::*;
    initial link = 3'h6;
    // Serial clock 160 ns, rests high between frames
    task automatic send(input logic [15:0] w, input int n, input logic cs_n);
        link.chip_select_n = cs_n;
        for (int i = n - 1; i >= 0; i--) begin
            link.serial_clk = 1'b0;
            link.serial_data_in = w[i];
            repeat (4) @(negedge clk_sys);
            link.serial_clk = 1'b1;
            repeat (4) @(negedge clk_sys);
        end
        link.chip_select_n = 1'b1;
        link.serial_data_in = ~link.serial_data_in;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ---- verification/tcdl_loader_test.sv ----
// Self-checking bench of the converter loader
`timescale 1ns/1ps
`default_nettype none
module tcdl_loader_test;
    import tcdl_pkg::*;
    logic clk_sys, rstn, midscale_preset_n, power_down_n, en, done;
    tcdl_link_t       link;
    logic [11:0][7:0] code, mir;
    logic [11:0][7:0] q[$];
    logic [11:0]      flt, sr;
    logic [31:0]      rnd;
    int               fail_count, cmp_count, cyc;
    tcdl_loader tcdl_loader_i (.clk_sys(clk_sys), .rstn(rstn), .link(link),
        .midscale_preset_n(midscale_preset_n), .power_down_n(power_down_n),
        .channel_code_reg(code), .output_float(flt), .converter_enable(en), .load_done(done));
    tcdl_host tcdl_host_i (.clk_sys(clk_sys), .link(link));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    // Note the expected channel set, then send the frame
    task automatic frame(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) sr = {sr[10:0], w[i]};
        if (sr[11:8] < 4'hc) mir[sr[11:8]] = sr[7:0];
        q.push_back(mir);
        tcdl_host_i.send(w, n, 1'b0);
    endtask
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Outputs are looked at on the falling edge, where they have settled
    always @(negedge clk_sys) begin
        if (rstn && done === 1'b1) begin
            if (q.size() == 0) begin
                fail_count++;
                $display("[ERR] %0t load without frame", $time);
            end else chk(code === q.pop_front());
        end
    end
    initial begin
        cyc = 0;
        while (cyc < 20000) begin
            @(posedge clk_sys);
            cyc++;
        end
        fail_count++;
        complete_run();
    end
    initial begin
        {rstn, midscale_preset_n, power_down_n} = 3'h3;
        fail_count = 0;
        cmp_count = 0;
        rnd = 32'h5c90_0ff6;
        sr = SHIFT_RESET;
        mir = {12{MIDSCALE_CODE}};
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        chk(code === mir && flt === 12'h000 && en === 1'b1);
        repeat (3) @(negedge clk_sys);
        for (int a = 0; a < 16; a++) begin
            rnd = lfsr(rnd);
            frame({4'h0, a[3:0], rnd[7:0]}, 12);
        end
        repeat (6) begin
            rnd = lfsr(rnd);
            frame(rnd[15:0], 12 + 4 * rnd[16]);
        end
        frame(16'h00a5, 8);
        tcdl_host_i.send(16'hffff, 12, 1'b1);
        frame(16'h0003, 4);
        $display("test done: loads");
        power_down_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(flt === 12'hfff && en === 1'b0 && code === mir);
        power_down_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(flt === 12'h000 && en === 1'b1 && code === mir);
        $display("test done: shutdown");
        midscale_preset_n = 1'b0;
        #1;
        mir = {12{MIDSCALE_CODE}};
        chk(code === mir);
        @(negedge clk_sys);
        midscale_preset_n = 1'b1;
        frame(16'h0b00, 12);
        frame(16'h0aff, 12);
        repeat (10) @(negedge clk_sys);
        chk(q.size() == 0);
        $display("test done: preset");
        complete_run();
    end
endmodule
`default_nettype wire

// ---- verification/tcdl_props.sv ----
// Port checker of the converter loader
`timescale 1ns/1ps
`default_nettype none
module tcdl_props
    import tcdl_pkg::*;
#(
    parameter int NCH = NUM_CHAN
) (
    input wire logic                       clk_sys,
    input wire logic                       rstn,
    input wire tcdl_pkg::tcdl_link_t       link,
    input wire logic                       midscale_preset_n,
    input wire logic                       power_down_n,
    input wire logic [NCH-1:0][CODE_W-1:0] channel_code_reg,
    input wire logic [NCH-1:0]             output_float,
    input wire logic                       converter_enable,
    input wire logic                       load_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [NCH-1:0][CODE_W-1:0] prev;
    logic [NCH-1:0]             chg;
    always_ff @(posedge clk_sys) prev <= channel_code_reg;
    always_comb for (int i = 0; i < NCH; i++) chg[i] = channel_code_reg[i] != prev[i];
    sequence s_cs_rise;
        !link.chip_select_n ##1 link.chip_select_n;
    endsequence
    a_preset_mid: assert property (!midscale_preset_n |-> channel_code_reg == {NCH{MIDSCALE_CODE}})
        else $error("preset left a code off midscale");
    a_float_follow: assert property (output_float == {NCH{!$past(power_down_n, 3)}})
        else $error("float flags do not follow shutdown");
    a_conv_off: assert property (converter_enable == $past(power_down_n, 3))
        else $error("converter enable does not follow shutdown");
    a_change_on_load: assert property ($changed(channel_code_reg) && midscale_preset_n |-> load_done)
        else $error("code changed without a load");
    a_one_chan: assert property (load_done |-> $onehot0(chg))
        else $error("more than one channel loaded");
    a_load_pulse: assert property (load_done |=> !load_done)
        else $error("load pulse too long");
    a_cs_load: assert property (s_cs_rise |-> ##[3:6] load_done)
        else $error("no load after select rise");
    a_idle_quiet: assert property (link.chip_select_n [*8] |-> !load_done)
        else $error("load while select idle");
endmodule
bind tcdl_loader tcdl_props #(.NCH(NCH)) tcdl_props_i (.clk_sys(clk_sys), .rstn(rstn),
    .link(link), .midscale_preset_n(midscale_preset_n), .power_down_n(power_down_n),
    .channel_code_reg(channel_code_reg), .output_float(output_float),
    .converter_enable(converter_enable), .load_done(load_done));
`default_nettype wire
